/* File: hdl/rps_pkg.sv */
// Constants, field layouts and carrier types for the receive port select and status bank.
// Assumes byte-wide register access delivered on the register-access clock.
package rps_pkg;

	localparam logic [7:0] RPS_ADDR_PORT_SEL = 8'h4C;
	localparam logic [7:0] RPS_ADDR_PORT_STS1 = 8'h4D;

	// Fields of the port-select register.
	localparam int RPS_SEL_PHYS_MSB = 7;
	localparam int RPS_SEL_PHYS_LSB = 6;
	localparam int RPS_SEL_READ_PORT = 4;
	localparam int RPS_SEL_WRITE_PORT_1 = 1;
	localparam int RPS_SEL_WRITE_PORT_0 = 0;

	// Fields of the per-port status register.
	localparam int RPS_STS_PORT_NUM = 6;
	localparam int RPS_STS_CRC = 5;
	localparam int RPS_STS_LOCK_CHG = 4;
	localparam int RPS_STS_LOCK = 0;

	// Reset values of the select state for each access context.
	localparam logic RPS_RST_READ_PORT_LOCAL = 1'b0;
	localparam logic RPS_RST_READ_PORT_CH0 = 1'b0;
	localparam logic RPS_RST_READ_PORT_CH1 = 1'b1;
	localparam logic [1:0] RPS_RST_WRITE_EN_LOCAL = 2'h0;
	localparam logic [1:0] RPS_RST_WRITE_EN_CH0 = 2'h1;
	localparam logic [1:0] RPS_RST_WRITE_EN_CH1 = 2'h2;
	localparam logic [1:0] RPS_PHYS_PORT_LOCAL = 2'h0;
	localparam logic [7:0] RPS_RDATA_NONE = 8'h00;

	// Source of an access: local host bus or the remote control channel.
	typedef enum logic {
		RPS_SRC_LOCAL = 1'b0,
		RPS_SRC_CHANNEL = 1'b1
	} rps_src_e;

	// One register access request.
	typedef struct packed {
		logic valid;
		logic write;
		rps_src_e src;
		logic port;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rps_req_s;

	// Access forwarded to the paged receiver registers.
	typedef struct packed {
		logic [1:0] wr_strobe;
		logic rd_strobe;
		logic rd_port;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rps_page_s;

endpackage : rps_pkg

/* File: hdl/rps_port_select.sv */
// Port-select register, per-port status register and paged-access steering for two receive ports.
// Assumes requests from the local host and the control channel are already merged, one per cycle,
// on the register-access clock; lock levels come from the receiver domain, CRC pulses do not.
//
// How it works
// - Local reads of the select register return physical port number zero.
// - Channel reads return the receive port number that carried the access.
// - Read-port bit picks which port page paged reads and status reads use.
// - Read-port bit resets to zero locally, to carrying port over the channel.
// - Each port has a write enable; paged writes go to every enabled port.
// - Write enables reset to zero locally; carrying port's enable resets to one.
// - Status port-number bit shows the currently selected read port.
// - Control-channel CRC error latches high and clears when status is read.
// - Lock change since the last status read latches high, clears on read.
// - Lowest status bit shows live lock state, not latched.
module rps_port_select
	import rps_pkg::*;
#(
	parameter int NUM_PORTS = 2
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire rps_req_s i_req,
	input wire logic [NUM_PORTS-1:0] i_lock,
	input wire logic [NUM_PORTS-1:0] i_crc_err,
	output logic o_rd_valid,
	output logic [7:0] o_rd_data,
	output rps_page_s o_page,
	output logic [NUM_PORTS-1:0] o_lock_change
);

	// Select state kept apart per context: local, channel over port 0, channel over port 1.
	localparam int NUM_CTX = 3;
	localparam int CTX_LOCAL = 0;
	localparam int CTX_CH0 = 1;
	localparam int CTX_CH1 = 2;
	// A remote page choice therefore never disturbs the local host's choice, and the reverse.
	// The enable pair and the one-bit page index limit the bank to two ports.

	logic [NUM_CTX-1:0] read_port;
	logic [NUM_CTX-1:0] next_read_port;
	logic [1:0] write_en [NUM_CTX];
	logic [1:0] next_write_en [NUM_CTX];

	logic [NUM_PORTS-1:0] lock_meta;
	logic [NUM_PORTS-1:0] lock_sync;
	logic [NUM_PORTS-1:0] lock_prev;
	logic [NUM_PORTS-1:0] crc_flag;
	logic [NUM_PORTS-1:0] next_crc_flag;
	logic [NUM_PORTS-1:0] chg_flag;
	logic [NUM_PORTS-1:0] next_chg_flag;

	// Next values of the registered outputs.
	logic next_rd_valid;
	logic [7:0] next_rd_data;
	rps_page_s next_page;

	// Maps an access source and carrying port to its context index.
	function automatic int ctx_of(input rps_src_e src, input logic port);
		if (src == RPS_SRC_LOCAL) begin
			return CTX_LOCAL;
		end
		return port ? CTX_CH1 : CTX_CH0;
	endfunction : ctx_of

	// True for a read request on the register bus.
	function automatic logic is_read(input rps_req_s r);
		return r.valid && !r.write;
	endfunction : is_read

	// Builds the status byte of one port.
	function automatic logic [7:0] status_byte(input logic port, input logic crc,
			input logic chg, input logic lock);
		logic [7:0] b;
		b = RPS_RDATA_NONE;
		b[RPS_STS_PORT_NUM] = port;
		b[RPS_STS_CRC] = crc;
		b[RPS_STS_LOCK_CHG] = chg;
		b[RPS_STS_LOCK] = lock;
		return b;
	endfunction : status_byte

	// Lock levels arrive from the receiver clock domain.
	// Changes are judged between the second flop and a third copy, so a level that is
	// still settling in the first flop is never compared.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lock_meta <= '0;
			lock_sync <= '0;
			lock_prev <= '0;
		end else begin
			lock_meta <= i_lock;
			lock_sync <= lock_meta;
			lock_prev <= lock_sync;
		end
	end

	// Select register next state.
	// Only the context that carried the write is updated; reserved bits are not stored.
	always_comb begin
		int c;
		c = ctx_of(i_req.src, i_req.port);
		next_read_port = read_port;
		for (int k = 0; k < NUM_CTX; k++) begin
			next_write_en[k] = write_en[k];
		end
		if (i_req.valid && i_req.write && i_req.addr == RPS_ADDR_PORT_SEL) begin
			next_read_port[c] = i_req.wdata[RPS_SEL_READ_PORT];
			next_write_en[c] = {i_req.wdata[RPS_SEL_WRITE_PORT_1],
				i_req.wdata[RPS_SEL_WRITE_PORT_0]};
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			read_port[CTX_LOCAL] <= RPS_RST_READ_PORT_LOCAL;
			read_port[CTX_CH0] <= RPS_RST_READ_PORT_CH0;
			read_port[CTX_CH1] <= RPS_RST_READ_PORT_CH1;
			write_en[CTX_LOCAL] <= RPS_RST_WRITE_EN_LOCAL;
			write_en[CTX_CH0] <= RPS_RST_WRITE_EN_CH0;
			write_en[CTX_CH1] <= RPS_RST_WRITE_EN_CH1;
		end else begin
			read_port <= next_read_port;
			for (int k = 0; k < NUM_CTX; k++) begin
				write_en[k] <= next_write_en[k];
			end
		end
	end

	// Latched status flags; a new event in the clearing cycle keeps the flag set.
	// The clear goes to the port selected by the reading context, whose byte was returned.
	always_comb begin
		int c;
		logic rp;
		c = ctx_of(i_req.src, i_req.port);
		rp = read_port[c];
		next_crc_flag = crc_flag;
		next_chg_flag = chg_flag;
		if (is_read(i_req) && i_req.addr == RPS_ADDR_PORT_STS1) begin
			next_crc_flag[rp] = 1'b0;
			next_chg_flag[rp] = 1'b0;
		end
		next_crc_flag = next_crc_flag | i_crc_err;
		next_chg_flag = next_chg_flag | (lock_sync ^ lock_prev);
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			crc_flag <= '0;
			chg_flag <= '0;
		end else begin
			crc_flag <= next_crc_flag;
			chg_flag <= next_chg_flag;
		end
	end

	// Read answers and paged access steering.
	always_comb begin
		int c;
		logic rp;
		c = ctx_of(i_req.src, i_req.port);
		rp = read_port[c];
		next_rd_valid = is_read(i_req);
		next_rd_data = RPS_RDATA_NONE;
		next_page = '0;
		next_page.addr = i_req.addr;
		next_page.wdata = i_req.wdata;
		next_page.rd_port = rp;
		if (is_read(i_req)) begin
			unique case (i_req.addr)
				RPS_ADDR_PORT_SEL: begin
					// A local access has no carrying port, so its number is fixed.
					// local physical port
					next_rd_data[RPS_SEL_PHYS_MSB:RPS_SEL_PHYS_LSB] =
						(i_req.src == RPS_SRC_LOCAL) ? RPS_PHYS_PORT_LOCAL : {1'b0, i_req.port};
					next_rd_data[RPS_SEL_READ_PORT] = rp;
					next_rd_data[RPS_SEL_WRITE_PORT_1] = write_en[c][1];
					next_rd_data[RPS_SEL_WRITE_PORT_0] = write_en[c][0];
				end
				RPS_ADDR_PORT_STS1: begin
					next_rd_data = status_byte(rp, crc_flag[rp], chg_flag[rp], lock_sync[rp]);
				end
				default: begin
					next_page.rd_strobe = 1'b1;
				end
			endcase
		end
		// Bank register writes never reach the pages; with both enables clear a write is dropped.
		if (i_req.valid && i_req.write && i_req.addr != RPS_ADDR_PORT_SEL
				&& i_req.addr != RPS_ADDR_PORT_STS1) begin
			next_page.wr_strobe = write_en[c];
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rd_valid <= 1'b0;
			o_rd_data <= RPS_RDATA_NONE;
			o_page <= '0;
			o_lock_change <= '0;
		end else begin
			o_rd_valid <= next_rd_valid;
			o_rd_data <= next_rd_data;
			o_page <= next_page;
			// The lock-change output shows each flag as it stands after this edge.
			o_lock_change <= next_chg_flag;
		end
	end

endmodule : rps_port_select

/* File: tb/rps_properties.sv */
// Checker for the port-select bank.
// Sees only the bank's ports; bound to every instance of the bank.
module rps_checker
	import rps_pkg::*;
#(parameter int NUM_PORTS = 2) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire rps_req_s i_req,
	input wire logic [NUM_PORTS-1:0] i_lock,
	input wire logic [NUM_PORTS-1:0] i_crc_err,
	input wire logic o_rd_valid,
	input wire logic [7:0] o_rd_data,
	input wire rps_page_s o_page,
	input wire logic [NUM_PORTS-1:0] o_lock_change
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	wire logic rd = i_req.valid && !i_req.write;
	wire logic paged = i_req.addr != RPS_ADDR_PORT_SEL && i_req.addr != RPS_ADDR_PORT_STS1;
	// Expected read port of each access context, kept from the select writes seen on the bus.
	wire logic [1:0] ctx = (i_req.src == RPS_SRC_LOCAL) ? 2'h0 : (i_req.port ? 2'h2 : 2'h1);
	logic [2:0] rp_model;
	wire logic rp_now = rp_model[ctx];
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rp_model <= 3'h4;
		end else if (i_req.valid && i_req.write && i_req.addr == RPS_ADDR_PORT_SEL) begin
			rp_model[ctx] <= i_req.wdata[RPS_SEL_READ_PORT];
		end
	end
	sequence sel_rd;
		rd && i_req.addr == RPS_ADDR_PORT_SEL;
	endsequence
	a_sel_phys_local: assert property (sel_rd ##0 i_req.src == RPS_SRC_LOCAL |=>
		o_rd_data[7:6] == 2'h0) else $error("local port number not zero");
	a_sel_phys_channel: assert property (sel_rd ##0 i_req.src == RPS_SRC_CHANNEL |=>
		o_rd_data[7:6] == {1'b0, $past(i_req.port)}) else $error("wrong carrying port");
	a_sel_reserved_zero: assert property (sel_rd |=>
		o_rd_data[5] == 1'b0 && o_rd_data[3:2] == 2'h0) else $error("reserved bits set");
	a_sts_port_bit: assert property (rd && i_req.addr == RPS_ADDR_PORT_STS1 |=>
		o_rd_data[7:6] == {1'b0, $past(rp_now)} && o_page.rd_port == $past(rp_now))
		else $error("status port bit wrong");
	a_paged_read_strobe: assert property (rd && paged |=>
		o_page.rd_strobe && o_rd_valid && o_rd_data == 8'h00) else $error("paged read");
	a_no_answer: assert property (!rd |=> !o_rd_valid && !o_page.rd_strobe)
		else $error("answer without read");
	a_write_strobe_only: assert property (!(i_req.valid && i_req.write && paged) |=>
		o_page.wr_strobe == 2'h0) else $error("stray write strobe");
	a_lock_change_set: assert property ($changed(i_lock[0]) |-> ##3 o_lock_change[0])
		else $error("lock change not latched");
endmodule : rps_checker

bind rps_port_select rps_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (.i_clk_sys(i_clk_sys),
	.i_rst_n(i_rst_n), .i_req(i_req), .i_lock(i_lock), .i_crc_err(i_crc_err),
	.o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_page(o_page), .o_lock_change(o_lock_change));

/* File: tb/rps_host_model.sv */
// Requester standing for the local host or the remote serializer.
// Assumes the bank takes a request on the edge where valid is high.
module rps_host_model
	import rps_pkg::*;
(
	input wire logic i_clk_sys,
	output rps_req_s o_req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_req = '0;
	// Released fields are inverted so stale values never look valid.
	task automatic access(input logic wr, input logic src, input logic port,
		input logic [7:0] addr, input logic [7:0] wd);
		@(posedge i_clk_sys);
		o_req <= '{1'b1, wr, rps_src_e'(src), port, addr, wd};
		@(posedge i_clk_sys);
		o_req <= '{1'b0, ~wr, rps_src_e'(~src), ~port, ~addr, ~wd};
	endtask : access
endmodule : rps_host_model

/* File: tb/test_rx_port_select_status.sv */
// Bench: random accesses from every context, compared against a model.
// Assumes the host model drives requests; lock and CRC come from here.
module test_rx_port_select_status import rps_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic [1:0] lock = 2'h0;
	logic [1:0] crc = 2'h0;
	logic [1:0] lchg, fcrc = 2'h0, fchg = 2'h0;
	logic rd_valid;
	logic [7:0] rd_data;
	rps_req_s req;
	rps_page_s page;
	logic [31:0] seed = 32'hA9EF;
	logic rp [3] = '{1'b0, 1'b0, 1'b1};
	logic [1:0] we [3] = '{2'h0, 2'h1, 2'h2};
	int bad_count = 0;
	int checks_done = 0;
	int cyc = 0;
	rps_port_select dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req(req), .i_lock(lock),
		.i_crc_err(crc), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_page(page),
		.o_lock_change(lchg));
	rps_host_model host (.i_clk_sys(i_clk_sys), .o_req(req));
	initial forever #25 i_clk_sys = ~i_clk_sys;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("MISMATCH at %0t: %s", $time, msg);
		end
	endtask : chk
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			close_out();
		end
	end
	initial begin
		logic [7:0] addr, exp;
		logic pg, p;
		int c;
		repeat (3) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		for (int n = 0; n < 400; n++) begin
			repeat (32) seed = lfsr(seed);
			@(posedge i_clk_sys);
			fchg = fchg | (seed[22:21] & seed[24:23]);
			fcrc = fcrc | (seed[26:25] & seed[28:27]);
			lock <= lock ^ (seed[22:21] & seed[24:23]);
			crc <= seed[26:25] & seed[28:27];
			@(posedge i_clk_sys);
			crc <= 2'h0;
			repeat (3) @(posedge i_clk_sys);
			chk(lchg === fchg, "lock change level");
			addr = seed[4] ? (seed[3] ? RPS_ADDR_PORT_STS1 : RPS_ADDR_PORT_SEL) : seed[12:5];
			c = seed[1] ? 1 + int'(seed[2]) : 0;
			p = rp[c];
			pg = addr != RPS_ADDR_PORT_SEL && addr != RPS_ADDR_PORT_STS1;
			case (addr)
				RPS_ADDR_PORT_SEL: exp = {1'b0, seed[1] & seed[2], 1'b0, p, 2'h0, we[c]};
				RPS_ADDR_PORT_STS1: exp = {1'b0, p, fcrc[p], fchg[p], 3'h0, lock[p]};
				default: exp = 8'h00;
			endcase
			host.access(seed[0], seed[1], seed[2], addr, seed[20:13]);
			#1;
			chk(rd_valid === !seed[0], "read answer");
			if (!seed[0]) chk(rd_data === exp, "read data");
			chk(page.wr_strobe === ((seed[0] && pg) ? we[c] : 2'h0), "write strobes");
			if (pg && !seed[0]) chk(page.rd_strobe === 1'b1 && page.rd_port === p, "page");
			chk(page.addr === addr && page.wdata === seed[20:13], "page address and data");
			if (addr == RPS_ADDR_PORT_SEL && seed[0]) begin
				rp[c] = seed[17];
				we[c] = seed[14:13];
			end
			if (addr == RPS_ADDR_PORT_STS1 && !seed[0]) begin
				fcrc[p] = 1'b0;
				fchg[p] = 1'b0;
			end
		end
		$display("Test random_access finished");
		close_out();
	end
endmodule : test_rx_port_select_status
